/* verif/ufa_autovector_bench.sv */
// self-checking bench for the shared interrupt autovector block
`timescale 1ns/100ps
`include "ufa_defs.svh"
module ufa_autovector_bench;
  import ufa_pkg::*;
  logic               clk, rst, busErrorPulse, usbSharedIrq, fifoSharedIrq, substValid;
  ufa_usb_event_type  usbEvent;
  ufa_fifo_event_type fifoEvent;
  ufa_fetch_type      coreFetch;
  logic [7:0]         substData, s_axi_awaddr, s_axi_araddr;
  logic [15:0]        fifoEntryAddr;
  logic [31:0]        s_axi_wdata, s_axi_rdata;
  logic [3:0]         s_axi_wstrb;
  logic [1:0]         s_axi_bresp, s_axi_rresp;
  logic               s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic               s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic               s_axi_rvalid, s_axi_rready;
  int                 errors, n_compared;

  ufa_autovector ufa_autovector_inst (.clk(clk), .rst(rst), .usbEvent(usbEvent),
    .fifoEvent(fifoEvent), .busErrorPulse(busErrorPulse), .usbSharedIrq(usbSharedIrq),
    .fifoSharedIrq(fifoSharedIrq), .coreFetch(coreFetch), .substValid(substValid),
    .substData(substData), .fifoEntryAddr(fifoEntryAddr), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready));
  ufa_core_model ufa_core_model_inst (.clk(clk), .coreFetch(coreFetch),
    .substValid(substValid), .substData(substData), .fifoEntryAddr(fifoEntryAddr));

  // 200 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      errors++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic give_verdict();
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic hang();
    errors++;
    $display("ERROR handshake expected answer seen none");
    give_verdict();
  endtask

  // one write: address and data offered together, bready held until bvalid
  task automatic axiWrite(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int i;
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hF;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (i = 0; i < 40; i++)
    begin
      @(posedge clk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid === 1'b1) break;
    end
    if (i == 40) hang();
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  // one read, rready held until rvalid
  task automatic axiRead(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int i;
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (i = 0; i < 40; i++)
    begin
      @(posedge clk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid === 1'b1) break;
    end
    if (i == 40) hang();
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [1:0] r;
    axiWrite(a, d, r);
    check("bresp", 32'(r), 32'(`UFA_RESP_OKAY));
  endtask

  task automatic rd(input string what, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    logic [1:0]  r;
    axiRead(a, d, r);
    check(what, d, exp);
    check("rresp", 32'(r), 32'(`UFA_RESP_OKAY));
  endtask

  task automatic pulseUsb(input ufa_usb_event_type ev);
    @(posedge clk) usbEvent <= ev;
    @(posedge clk) usbEvent <= '0;
  endtask

  // usb pending bit of an event field bit; gaps sit at reserved priorities and the bus error bit
  function automatic int pendBit(input int idx);
    if (idx < 7) return idx;
    if (idx < 16) return idx + 1;
    if (idx < 22) return idx + 2;
    return idx + 6;
  endfunction

  // status word: irq bits, fifo vector, usb vector
  function automatic logic [31:0] stat(input logic [1:0] irq, input int fv, input int uv);
    return {14'h0, irq, 8'(fv), 8'(uv)};
  endfunction

  initial
  begin
    logic [31:0]        d;
    logic [1:0]         r;
    logic [15:0]        tgt;
    ufa_usb_event_type  ev;
    ufa_fifo_event_type fe;
    int                 n;
    errors = 0;
    n_compared = 0;
    rst = 1'b1;
    {usbEvent, fifoEvent, busErrorPulse} = '0;
    {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    // reset values, unmapped and read-only places
    rd("setup", `UFA_OFF_SETUP, 32'h0);
    rd("usb enable", `UFA_OFF_USB_EN, 32'h0);
    rd("error limit", `UFA_OFF_ERR_LIM, 32'h4);
    rd("status", `UFA_OFF_VECTOR, stat(2'b00, 8'h80, 8'h00));
    check("entry", 32'(fifoEntryAddr), 32'h53);
    axiRead(8'h1C, d, r);
    check("unmapped data", d, 32'h0);
    check("unmapped rresp", 32'(r), 32'(`UFA_RESP_SLVERR));
    axiWrite(8'h20, 32'hFFFF_FFFF, r);
    check("unmapped bresp", 32'(r), 32'(`UFA_RESP_SLVERR));
    wr(`UFA_OFF_VECTOR, 32'hFFFF_FFFF);
    rd("status ro", `UFA_OFF_VECTOR, stat(2'b00, 8'h80, 8'h00));
    $display("test reset done");
    // every usb source alone
    wr(`UFA_OFF_USB_EN, 32'hFFFF_FFFF);
    rd("usb enable", `UFA_OFF_USB_EN, ~`UFA_USB_RSVD);
    for (n = 0; n < 26; n++)
    begin
      ev = '0;
      ev[n] = 1'b1;
      pulseUsb(ev);
      rd("usb pend", `UFA_OFF_USB_PEND, 32'h1 << pendBit(n));
      rd("usb vector", `UFA_OFF_VECTOR, stat(2'b01, 8'h80, 4 * pendBit(n)));
      wr(`UFA_OFF_USB_PEND, 32'h1 << pendBit(n));
    end
    rd("usb cleared", `UFA_OFF_USB_PEND, 32'h0);
    $display("test usb sources done");
    // limit 2: the third bus error fires
    wr(`UFA_OFF_ERR_LIM, 32'h2);
    for (n = 1; n <= 3; n++)
    begin
      @(posedge clk) busErrorPulse <= 1'b1;
      @(posedge clk) busErrorPulse <= 1'b0;
      rd("error pend", `UFA_OFF_USB_PEND, (n == 3) ? 32'h0100_0000 : 32'h0);
    end
    rd("error vector", `UFA_OFF_VECTOR, stat(2'b01, 8'h80, 8'h60));
    wr(`UFA_OFF_USB_PEND, 32'h0100_0000);
    // every fifo source alone
    wr(`UFA_OFF_FIFO_EN, 32'h3FFF);
    for (n = 0; n < 14; n++)
    begin
      fe = '0;
      fe[n] = 1'b1;
      @(posedge clk) fifoEvent <= fe;
      @(posedge clk) fifoEvent <= '0;
      rd("fifo vector", `UFA_OFF_VECTOR, stat(2'b10, 8'h80 + 4 * n, 8'h00));
      wr(`UFA_OFF_FIFO_PEND, 32'h1 << n);
    end
    $display("test fifo sources done");
    // two pending usb sources: the higher one shows until masked or cleared
    ev = '0;
    ev[1] = 1'b1;
    ev[25] = 1'b1;
    pulseUsb(ev);
    rd("both", `UFA_OFF_VECTOR, stat(2'b01, 8'h80, 8'h04));
    wr(`UFA_OFF_USB_EN, 32'hFFFF_FFFD);
    rd("masked", `UFA_OFF_VECTOR, stat(2'b01, 8'h80, 8'h7C));
    wr(`UFA_OFF_USB_EN, 32'hFFFF_FFFF);
    wr(`UFA_OFF_USB_PEND, 32'h2);
    rd("next", `UFA_OFF_VECTOR, stat(2'b01, 8'h80, 8'h7C));
    wr(`UFA_OFF_USB_PEND, 32'h8000_0000);
    rd("none", `UFA_OFF_VECTOR, stat(2'b00, 8'h80, 8'h00));
    check("usb irq", 32'(usbSharedIrq), 32'h0);
    $display("test priority done");
    // operand substitution during vector fetches
    ev = '0;
    ev[12] = 1'b1;
    pulseUsb(ev);
    @(posedge clk) fifoEvent <= 14'h1000;
    @(posedge clk) fifoEvent <= '0;
    ufa_core_model_inst.takeVector(1'b0, tgt);
    check("usb off", 32'(tgt), {16'h0, ufa_core_model_inst.USB_PAGE, 8'hEE});
    check("usb irq on", 32'(usbSharedIrq), 32'h1);
    check("fifo irq on", 32'(fifoSharedIrq), 32'h1);
    wr(`UFA_OFF_SETUP, 32'h1);
    ufa_core_model_inst.takeVector(1'b0, tgt);
    check("usb on", 32'(tgt), {16'h0, ufa_core_model_inst.USB_PAGE, 8'h34});
    ufa_core_model_inst.takeVector(1'b1, tgt);
    check("fifo off", 32'(tgt), {16'h0, ufa_core_model_inst.FIFO_PAGE, 8'hEE});
    wr(`UFA_OFF_SETUP, 32'h3);
    ufa_core_model_inst.takeVector(1'b1, tgt);
    check("fifo on", 32'(tgt), {16'h0, ufa_core_model_inst.FIFO_PAGE, 8'hB0});
    check("entry", 32'(ufa_core_model_inst.lastEntry), 32'h53);
    $display("test autovector done");
    // second reset in mid-run
    @(posedge clk) rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rd("status again", `UFA_OFF_VECTOR, stat(2'b00, 8'h80, 8'h00));
    rd("setup again", `UFA_OFF_SETUP, 32'h0);
    $display("test second reset done");
    give_verdict();
  end
endmodule

/* verif/ufa_autovector_checker.sv */
// concurrent checks on the ports of the shared interrupt autovector block
`timescale 1ns/100ps
module ufa_autovector_checker #(
  parameter int ERR_CNT_W = 4
) (
  input wire logic                   clk,
  input wire logic                   rst,
  input wire logic                   usbSharedIrq,
  input wire logic                   fifoSharedIrq,
  input wire ufa_pkg::ufa_fetch_type coreFetch,
  input wire logic                   substValid,
  input wire logic [7:0]             substData,
  input wire logic [15:0]            fifoEntryAddr,
  input wire logic                   s_axi_bvalid
);
  import ufa_pkg::*;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  // a usb fetch one cycle back
  sequence usbSubst;
    substValid && $past(coreFetch.addr) == 16'h0045;
  endsequence

  chk_entry_addr: assert property (fifoEntryAddr == 16'h0053)
    else $error("fifo entry address wrong");
  chk_subst_cause: assert property (substValid |-> $past(coreFetch.valid) &&
    ($past(coreFetch.addr) == 16'h0045 || $past(coreFetch.addr) == 16'h0055))
    else $error("substitution without operand fetch");
  chk_no_subst: assert property (coreFetch.valid && coreFetch.addr != 16'h0045 &&
    coreFetch.addr != 16'h0055 |=> !substValid)
    else $error("substitution on other address");
  chk_usb_step: assert property (usbSubst |-> substData[1:0] == 2'h0 && !substData[7])
    else $error("usb vector off step");
  chk_usb_reserved: assert property (usbSubst |->
    !(substData inside {8'h1C, 8'h44, 8'h64, 8'h68, 8'h6C}))
    else $error("usb vector on reserved code");
  chk_fifo_range: assert property (substValid && $past(coreFetch.addr) == 16'h0055 |->
    substData >= 8'h80 && substData <= 8'hB4 && substData[1:0] == 2'h0)
    else $error("fifo vector out of range");
  chk_usb_hold: assert property ($fell(usbSharedIrq) |-> $past(s_axi_bvalid) ||
    $past(s_axi_bvalid, 2) || $past(s_axi_bvalid, 3))
    else $error("usb request dropped without write");
  chk_fifo_hold: assert property ($fell(fifoSharedIrq) |-> $past(s_axi_bvalid) ||
    $past(s_axi_bvalid, 2) || $past(s_axi_bvalid, 3))
    else $error("fifo request dropped without write");

  // main scenarios
  cov_usb_subst: cover property (usbSubst);
  cov_fifo_subst: cover property (substValid && $past(coreFetch.addr) == 16'h0055);
  cov_usb_fall: cover property ($fell(usbSharedIrq));
endmodule

bind ufa_autovector ufa_autovector_checker #(.ERR_CNT_W(ERR_CNT_W)) ufa_autovector_checker_inst (
  .clk(clk), .rst(rst), .usbSharedIrq(usbSharedIrq), .fifoSharedIrq(fifoSharedIrq),
  .coreFetch(coreFetch), .substValid(substValid), .substData(substData),
  .fifoEntryAddr(fifoEntryAddr), .s_axi_bvalid(s_axi_bvalid));

/* verif/ufa_core_model.sv */
// behavioural processor core fetching interrupt vectors
`timescale 1ns/100ps
module ufa_core_model (
  input  wire logic              clk,
  output ufa_pkg::ufa_fetch_type coreFetch,
  input  wire logic              substValid,
  input  wire logic [7:0]        substData,
  input  wire logic [15:0]       fifoEntryAddr
);
  import ufa_pkg::*;
  localparam logic [7:0] USB_PAGE  = 8'h3A;
  localparam logic [7:0] FIFO_PAGE = 8'h5B;
  localparam logic [7:0] FILLER    = 8'hEE;
  logic [15:0] lastEntry;

  // no fetch until asked
  initial coreFetch = '0;

  // code memory as firmware leaves it: page bytes preloaded
  function automatic logic [7:0] codeByte(input logic [15:0] a);
    if (a == 16'h0044) return USB_PAGE;
    if (a == 16'h0054) return FIFO_PAGE;
    return FILLER;
  endfunction

  // one operand fetch; a substituted byte overrides memory
  task automatic fetchByte(input logic [15:0] a, output logic [7:0] d);
    int i;
    @(posedge clk);
    coreFetch <= '{valid: 1'b1, addr: a};
    @(posedge clk);
    coreFetch <= '0;
    d = codeByte(a);
    for (i = 0; i < 2; i++)
    begin
      #1;
      if (substValid === 1'b1) d = substData;
      @(posedge clk);
    end
  endtask

  // vector a jump: fifo enters through the entry address first
  task automatic takeVector(input logic fifo, output logic [15:0] target);
    logic [7:0] page;
    logic [7:0] low;
    if (fifo) lastEntry = fifoEntryAddr;
    fetchByte(fifo ? 16'h0054 : 16'h0044, page);
    fetchByte(fifo ? 16'h0055 : 16'h0045, low);
    target = {page, low};
  endtask
endmodule

/* verilog/ufa_autovector.sv */
// shared usb and fifo interrupt prioritiser with autovector substitution
//
// The AXI4-Lite register port and the register offsets were chosen for this implementation.
`timescale 1ns/100ps
`include "ufa_defs.svh"

module ufa_autovector #(
  parameter int ERR_CNT_W = 4
) (
  input  wire logic                       clk,
  input  wire logic                       rst,
  // event sources
  input  wire ufa_pkg::ufa_usb_event_type  usbEvent,
  input  wire ufa_pkg::ufa_fifo_event_type fifoEvent,
  input  wire logic                       busErrorPulse,
  // core side
  output logic                            usbSharedIrq,
  output logic                            fifoSharedIrq,
  input  wire ufa_pkg::ufa_fetch_type      coreFetch,
  output logic                            substValid,
  output logic [7:0]                      substData,
  output logic [15:0]                     fifoEntryAddr,
  // axi4-lite slave
  input  wire logic [7:0]                 s_axi_awaddr,
  input  wire logic                       s_axi_awvalid,
  output logic                            s_axi_awready,
  input  wire logic [31:0]                s_axi_wdata,
  input  wire logic [3:0]                 s_axi_wstrb,
  input  wire logic                       s_axi_wvalid,
  output logic                            s_axi_wready,
  output logic [1:0]                      s_axi_bresp,
  output logic                            s_axi_bvalid,
  input  wire logic                       s_axi_bready,
  input  wire logic [7:0]                 s_axi_araddr,
  input  wire logic                       s_axi_arvalid,
  output logic                            s_axi_arready,
  output logic [31:0]                     s_axi_rdata,
  output logic [1:0]                      s_axi_rresp,
  output logic                            s_axi_rvalid,
  input  wire logic                       s_axi_rready
);
  import ufa_pkg::*;

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  logic [1:0]           setup_q;
  logic [31:0]          usbPend_q;
  logic [31:0]          usbPend_d;
  logic [31:0]          usbEn_q;
  logic [13:0]          fifoPend_q;
  logic [13:0]          fifoPend_d;
  logic [13:0]          fifoEn_q;
  logic [ERR_CNT_W-1:0] bus_error_limit_q;
  logic [ERR_CNT_W-1:0] errCount_q;
  logic                 errHit;
  logic [31:0]          usbSet;
  logic [13:0]          fifoSet;
  logic [31:0]          usbActive;
  logic [13:0]          fifoActive;
  logic [7:0]           usbVec_q;
  logic [7:0]           fifoVec_q;
  logic [7:0]           awAddr_q;
  logic                 awHeld_q;
  logic [31:0]          wData_q;
  logic [3:0]           wStrb_q;
  logic                 wHeld_q;
  logic                 doWrite;
  logic [31:0]          byteMask;
  logic [31:0]          wrClear;
  logic                 wrMapped;
  logic                 rdMapped;
  logic [31:0]          rdWord;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // index of the lowest set bit, which is the best priority
  function automatic logic [4:0] lowestIdx(input logic [31:0] v);
    logic [4:0] r;
    r = 5'h00;
    for (int i = 31; i >= 0; i--)
    begin
      if (v[i])
      begin
        r = i[4:0];
      end
    end
    return r;
  endfunction

  // ----------------------------------------------------------------
  // source mapping
  // ----------------------------------------------------------------
  // usb set vector, bit n is priority n+1, code 4*n
  assign usbSet = {usbEvent.isoSequenceError,
                   3'b000,
                   errHit,
                   usbEvent.endpointPingNak,
                   1'b0,
                   usbEvent.inBulkNak,
                   usbEvent.endpointBuffer,
                   usbEvent.ep1Out,
                   usbEvent.ep1In,
                   usbEvent.ep0Out,
                   usbEvent.ep0In,
                   1'b0,
                   usbEvent.controlHandshakeAcked,
                   usbEvent.highSpeedEntered,
                   usbEvent.busReset,
                   usbEvent.suspend,
                   usbEvent.setupTokenSeen,
                   usbEvent.startOfFrame,
                   usbEvent.setupDataReady};

  // fifo set vector, bit n is priority n+1, code 80 + 4*n
  assign fifoSet = {fifoEvent.waveformEngineEvent,
                    fifoEvent.waveformEngineDone,
                    fifoEvent.endpointFullFlag,
                    fifoEvent.endpointEmptyFlag,
                    fifoEvent.endpointLevelFlag};

  // ----------------------------------------------------------------
  // bus error limit
  // ----------------------------------------------------------------
  // an error beyond the programmed count fires and restarts the count
  assign errHit = busErrorPulse && (errCount_q >= bus_error_limit_q);

  // error counter
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      errCount_q <= '0;
    end
    else if (errHit)
    begin
      errCount_q <= '0;
    end
    else if (busErrorPulse)
    begin
      errCount_q <= errCount_q + 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // pending flags
  // ----------------------------------------------------------------
  // set wins over a clear in the same cycle
  always_comb
  begin
    usbPend_d  = ((usbPend_q & ~wrClear) | usbSet) & ~`UFA_USB_RSVD;
    fifoPend_d = (fifoPend_q & ~wrClear[13:0]) | fifoSet;
  end

  // pending registers
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      usbPend_q  <= '0;
      fifoPend_q <= '0;
    end
    else
    begin
      usbPend_q  <= usbPend_d;
      fifoPend_q <= fifoPend_d;
    end
  end

  assign usbActive  = usbPend_q & usbEn_q;
  assign fifoActive = fifoPend_q & fifoEn_q;

  // ----------------------------------------------------------------
  // requests and vectors
  // ----------------------------------------------------------------
  // shared requests and encoded vectors
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      usbSharedIrq  <= 1'b0;
      fifoSharedIrq <= 1'b0;
      usbVec_q      <= `UFA_USB_BASE;
      fifoVec_q     <= `UFA_FIFO_BASE;
    end
    else
    begin
      usbSharedIrq  <= |usbActive;
      fifoSharedIrq <= |fifoActive;
      usbVec_q      <= `UFA_USB_BASE | {1'b0, lowestIdx(usbActive), 2'b00};
      fifoVec_q     <= `UFA_FIFO_BASE
                       | {1'b0, lowestIdx({18'h00000, fifoActive}), 2'b00};
    end
  end

  // ----------------------------------------------------------------
  // core operand substitution
  // ----------------------------------------------------------------
  // answer one cycle after a fetch of a vector operand address
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      substValid    <= 1'b0;
      substData     <= 8'h00;
      fifoEntryAddr <= `UFA_FIFO_ENTRY;
    end
    else
    begin
      fifoEntryAddr <= `UFA_FIFO_ENTRY;
      substValid    <= 1'b0;
      substData     <= 8'h00;
      if (coreFetch.valid && setup_q[`UFA_BIT_USB_AV]
          && coreFetch.addr == `UFA_USB_VEC_ADDR)
      begin
        substValid <= 1'b1;
        substData  <= usbVec_q;
      end
      else if (coreFetch.valid && setup_q[`UFA_BIT_FIFO_AV]
               && coreFetch.addr == `UFA_FIFO_VEC_ADDR)
      begin
        substValid <= 1'b1;
        substData  <= fifoVec_q;
      end
    end
  end

  // ----------------------------------------------------------------
  // axi4-lite write path
  // ----------------------------------------------------------------
  assign s_axi_awready = !awHeld_q;
  assign s_axi_wready  = !wHeld_q;
  assign doWrite       = awHeld_q && wHeld_q && !s_axi_bvalid;

  // latch address and data independently
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      awHeld_q <= 1'b0;
      awAddr_q <= 8'h00;
      wHeld_q  <= 1'b0;
      wData_q  <= 32'h0000_0000;
      wStrb_q  <= 4'h0;
    end
    else
    begin
      if (s_axi_awvalid && !awHeld_q)
      begin
        awHeld_q <= 1'b1;
        awAddr_q <= s_axi_awaddr;
      end
      else if (doWrite)
      begin
        awHeld_q <= 1'b0;
      end
      if (s_axi_wvalid && !wHeld_q)
      begin
        wHeld_q <= 1'b1;
        wData_q <= s_axi_wdata;
        wStrb_q <= s_axi_wstrb;
      end
      else if (doWrite)
      begin
        wHeld_q <= 1'b0;
      end
    end
  end

  // byte lanes and decode
  always_comb
  begin
    byteMask = {{8{wStrb_q[3]}}, {8{wStrb_q[2]}}, {8{wStrb_q[1]}}, {8{wStrb_q[0]}}};
    wrMapped = 1'b0;
    wrClear  = 32'h0000_0000;
    unique case (awAddr_q)
      `UFA_OFF_SETUP, `UFA_OFF_USB_EN, `UFA_OFF_FIFO_EN, `UFA_OFF_ERR_LIM,
      `UFA_OFF_VECTOR:
        wrMapped = 1'b1;
      `UFA_OFF_USB_PEND:
      begin
        wrMapped = 1'b1;
        wrClear  = doWrite ? (wData_q & byteMask) : 32'h0000_0000;
      end
      `UFA_OFF_FIFO_PEND:
      begin
        wrMapped = 1'b1;
        wrClear  = doWrite ? {18'h00000, wData_q[13:0] & byteMask[13:0]} : 32'h0000_0000;
      end
      default:
        wrMapped = 1'b0;
    endcase
  end

  // control registers
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      setup_q    <= `UFA_RST_SETUP;
      usbEn_q    <= `UFA_RST_USB_EN;
      fifoEn_q   <= `UFA_RST_FIFO_EN;
      bus_error_limit_q <= ERR_CNT_W'(`UFA_RST_ERR_LIM);
    end
    else if (doWrite)
    begin
      if (awAddr_q == `UFA_OFF_SETUP && wStrb_q[0])
      begin
        setup_q <= wData_q[1:0];
      end
      if (awAddr_q == `UFA_OFF_USB_EN)
      begin
        usbEn_q <= ((usbEn_q & ~byteMask) | (wData_q & byteMask)) & ~`UFA_USB_RSVD;
      end
      if (awAddr_q == `UFA_OFF_FIFO_EN)
      begin
        fifoEn_q <= (fifoEn_q & ~byteMask[13:0]) | (wData_q[13:0] & byteMask[13:0]);
      end
      if (awAddr_q == `UFA_OFF_ERR_LIM && wStrb_q[0])
      begin
        bus_error_limit_q <= wData_q[ERR_CNT_W-1:0];
      end
    end
  end

  // write response
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `UFA_RESP_OKAY;
    end
    else if (doWrite)
    begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wrMapped ? `UFA_RESP_OKAY : `UFA_RESP_SLVERR;
    end
    else if (s_axi_bready)
    begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // axi4-lite read path
  // ----------------------------------------------------------------
  assign s_axi_arready = !s_axi_rvalid;

  // read decode
  always_comb
  begin
    rdMapped = 1'b1;
    rdWord   = 32'h0000_0000;
    unique case (s_axi_araddr)
      `UFA_OFF_SETUP:     rdWord = {30'h0, setup_q};
      `UFA_OFF_USB_PEND:  rdWord = usbPend_q;
      `UFA_OFF_USB_EN:    rdWord = usbEn_q;
      `UFA_OFF_FIFO_PEND: rdWord = {18'h00000, fifoPend_q};
      `UFA_OFF_FIFO_EN:   rdWord = {18'h00000, fifoEn_q};
      `UFA_OFF_VECTOR:    rdWord = {14'h0000, fifoSharedIrq, usbSharedIrq,
                                    fifoVec_q, usbVec_q};
      `UFA_OFF_ERR_LIM:   rdWord = {{(32-ERR_CNT_W){1'b0}}, bus_error_limit_q};
      default:            rdMapped = 1'b0;
    endcase
  end

  // read data and response
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= `UFA_RESP_OKAY;
    end
    else if (s_axi_arvalid && !s_axi_rvalid)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rdWord;
      s_axi_rresp  <= rdMapped ? `UFA_RESP_OKAY : `UFA_RESP_SLVERR;
    end
    else if (s_axi_rready)
    begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule

/* verilog/ufa_defs.svh */
// constants of the shared interrupt autovector block
`ifndef UFA_DEFS_SVH
`define UFA_DEFS_SVH

// register byte offsets
`define UFA_OFF_SETUP     8'h00
`define UFA_OFF_USB_PEND  8'h04
`define UFA_OFF_USB_EN    8'h08
`define UFA_OFF_FIFO_PEND 8'h0C
`define UFA_OFF_FIFO_EN   8'h10
`define UFA_OFF_VECTOR    8'h14
`define UFA_OFF_ERR_LIM   8'h18

// field positions
`define UFA_BIT_USB_AV    0
`define UFA_BIT_FIFO_AV   1
`define UFA_BIT_USB_IRQ   16
`define UFA_BIT_FIFO_IRQ  17

// reset values
`define UFA_RST_SETUP     2'h0
`define UFA_RST_USB_EN    32'h0000_0000
`define UFA_RST_FIFO_EN   14'h0000
`define UFA_RST_ERR_LIM   4'h4

// usb sources that never exist: priorities 8, 18, 26, 27, 28
`define UFA_USB_RSVD      32'h0E02_0080

// vector code bases
`define UFA_USB_BASE      8'h00
`define UFA_FIFO_BASE     8'h80

// core fetch addresses
`define UFA_USB_PAGE_ADDR 16'h0044
`define UFA_USB_VEC_ADDR  16'h0045
`define UFA_FIFO_ENTRY    16'h0053
`define UFA_FIFO_PAGE_ADDR 16'h0054
`define UFA_FIFO_VEC_ADDR 16'h0055

// bus responses
`define UFA_RESP_OKAY     2'h0
`define UFA_RESP_SLVERR   2'h2

`endif

/* verilog/ufa_pkg.sv */
// types of the shared interrupt autovector block
package ufa_pkg;

  // usb engine events, one-cycle pulses; 4-bit vectors index ep2,ep4,ep6,ep8 from bit 0
  typedef struct packed {
    logic [3:0] isoSequenceError;
    logic [5:0] endpointPingNak;   // ep0, ep1, ep2, ep4, ep6, ep8
    logic       inBulkNak;
    logic [3:0] endpointBuffer;
    logic       ep1Out;
    logic       ep1In;
    logic       ep0Out;
    logic       ep0In;
    logic       controlHandshakeAcked;
    logic       highSpeedEntered;
    logic       busReset;
    logic       suspend;
    logic       setupTokenSeen;
    logic       startOfFrame;
    logic       setupDataReady;
  } ufa_usb_event_type;

  // fifo and waveform engine events, one-cycle pulses
  typedef struct packed {
    logic       waveformEngineEvent;
    logic       waveformEngineDone;
    logic [3:0] endpointFullFlag;
    logic [3:0] endpointEmptyFlag;
    logic [3:0] endpointLevelFlag;
  } ufa_fifo_event_type;

  // core operand fetch request
  typedef struct packed {
    logic        valid;
    logic [15:0] addr;
  } ufa_fetch_type;

endpackage
